// ---- verilog/sw_chan_ctrl.sv ----
// Channel source selection, protection latches and open-load diagnosis.
// Assumes decoded serial frames arrive as one-cycle strobes synchronous to clk.
`timescale 1ns/1ps
`include "sw_cfg.svh"

// Summary of operation
// - Two-bit source fields, two channels per register.
// - Codes: off, input 1, input 2/3, on.
// - Overload switches channel off within 60 us.
// - Protected channel stays off until latch cleared.
// - Clear-latch bit self-clears on next frame other than another clear write of one.
// - Over-temperature switches channel off, sets flag.
// - Over-temperature flag set even when off.
// - Fault flags stay latched until clear command.
// - Open-load flag clears on diagnosis register read.
// - Open-load filtered, only while channel off.
// - Per-channel diagnosis current enable bit.
module sw_chan_ctrl #(
    parameter int CW = `SW_CW,
    parameter logic [CW-1:0] OVL_CYC = CW'(`SW_OVL_CYC),
    parameter logic [CW-1:0] OL_CYC = CW'(`SW_OL_CYC),
    parameter logic [`SW_NCH-1:0] IN3_MASK = `SW_IN3_MASK
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic frame_valid,
    input wire sw_pkg::sw_frame_t frame,
    input wire logic in1,
    input wire logic in2,
    input wire logic in3,
    input wire logic [`SW_NCH-1:0] overload,
    input wire logic [`SW_NCH-1:0] overtemp,
    input wire logic [`SW_NCH-1:0] ol_sense,
    output logic [`SW_NCH-1:0] ch_on,
    output logic [`SW_NCH-1:0] diag_current_enable,
    output logic [`SW_NCH-1:0] protect_fault_flag,
    output logic [`SW_NCH-1:0] open_load_flag,
    output logic clear_latch_bit,
    output logic [`SW_DW-1:0] rdata
);
    import sw_pkg::*;

    logic rst_meta_reg;
    logic rst_n_sync;
    logic [2*`SW_NCH-1:0] sel_reg;
    logic [`SW_NCH-1:0] src_on;
    logic [`SW_NCH-1:0] fault_ev;
    logic [`SW_NCH-1:0] ol_set;
    logic [`SW_NCH-1:0] prot_next;
    logic [CW-1:0] ovl_cnt [`SW_NCH];
    logic [CW-1:0] ol_cnt [`SW_NCH];
    logic wr_sel;
    logic wr_dcen;
    logic wr_cmd;
    logic rd_ol;

    // Reset is released through two flip-flops.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    assign wr_sel = frame_valid && frame.write && (frame.addr <= `SW_IDX_SEL3);
    assign wr_dcen = frame_valid && frame.write && (frame.addr == `SW_IDX_DCEN);
    assign wr_cmd = frame_valid && frame.write && (frame.addr == `SW_IDX_CMD);
    assign rd_ol = frame_valid && !frame.write && (frame.addr == `SW_IDX_OL);

    // Source select registers hold channel 2k in bits [1:0] and 2k+1 in [3:2].
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            sel_reg <= `SW_SEL_RST;
        else if (wr_sel)
            sel_reg[frame.addr[1:0]*`SW_SEL_W +: `SW_SEL_W] <= frame.wdata[`SW_SEL_W-1:0];
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            diag_current_enable <= `SW_DCEN_RST;
        else if (wr_dcen)
            diag_current_enable <= frame.wdata;
    end

    // The clear command is set by a write of one and dropped by any later frame other than another write of one.
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            clear_latch_bit <= 1'b0;
        else if (frame_valid)
            clear_latch_bit <= wr_cmd && frame.wdata[`SW_CPL_BIT];
    end

    genvar i;
    generate
        for (i = 0; i < `SW_NCH; i++)
        begin : g_ch
            always_comb
            begin
                case (sel_reg[2*i +: 2])
                    `SW_SRC_OFF: src_on[i] = 1'b0;
                    `SW_SRC_IN1: src_on[i] = in1;
                    `SW_SRC_IN23: src_on[i] = IN3_MASK[i] ? in3 : in2;
                    `SW_SRC_ON: src_on[i] = 1'b1;
                    default: src_on[i] = 1'b0;
                endcase
            end

            // Overload must persist while the channel is on for the full delay.
            always_ff @(posedge clk or negedge rst_n_sync)
            begin
                if (!rst_n_sync)
                    ovl_cnt[i] <= '0;
                else if (!(overload[i] && ch_on[i]))
                    ovl_cnt[i] <= '0;
                else if (ovl_cnt[i] != OVL_CYC - 1'b1)
                    ovl_cnt[i] <= ovl_cnt[i] + 1'b1;
            end

            assign fault_ev[i] = (overload[i] && ch_on[i] && ovl_cnt[i] == OVL_CYC - 1'b1)
                || overtemp[i];

            // A new fault wins over a clear in the same cycle.
            assign prot_next[i] = fault_ev[i] || (protect_fault_flag[i] && !clear_latch_bit);

            // Open-load filter runs only while the output is off.
            always_ff @(posedge clk or negedge rst_n_sync)
            begin
                if (!rst_n_sync)
                    ol_cnt[i] <= '0;
                else if (ch_on[i] || !ol_sense[i])
                    ol_cnt[i] <= '0;
                else if (ol_cnt[i] != OL_CYC - 1'b1)
                    ol_cnt[i] <= ol_cnt[i] + 1'b1;
            end

            assign ol_set[i] = !ch_on[i] && ol_sense[i] && ol_cnt[i] == OL_CYC - 1'b1;
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            protect_fault_flag <= `SW_ZERO8;
        else
            protect_fault_flag <= prot_next;
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            ch_on <= `SW_ZERO8;
        else
            ch_on <= src_on & ~prot_next;
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            open_load_flag <= `SW_ZERO8;
        else
            open_load_flag <= ol_set | (open_load_flag & ~{`SW_NCH{rd_ol}});
    end

    // Read data is captured on the frame strobe, before any read side effect.
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            rdata <= `SW_ZERO8;
        else if (frame_valid && !frame.write)
        begin
            case (frame.addr)
                `SW_IDX_SEL0, `SW_IDX_SEL1, `SW_IDX_SEL2, `SW_IDX_SEL3:
                    rdata <= {4'h0, sel_reg[frame.addr[1:0]*`SW_SEL_W +: `SW_SEL_W]};
                `SW_IDX_DCEN: rdata <= diag_current_enable;
                `SW_IDX_CMD: rdata <= {7'h00, clear_latch_bit};
                `SW_IDX_PFLT: rdata <= protect_fault_flag;
                `SW_IDX_OL: rdata <= open_load_flag;
                default: rdata <= `SW_ZERO8;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_sync);

    chk_sel_write: assert property (wr_sel && frame.addr == `SW_IDX_SEL0 |=>
        sel_reg[3:0] == $past(frame.wdata[3:0]))
        else $error("Source select write not stored.");
    chk_src_off: assert property (sel_reg[1:0] == `SW_SRC_OFF |=> !ch_on[0])
        else $error("Channel on with source off.");
    chk_src_forced_on: assert property (sel_reg[1:0] == `SW_SRC_ON && !prot_next[0]
        |=> ch_on[0])
        else $error("Forced-on channel not on.");
    chk_ovl_shutdown: assert property (overload[0] && ch_on[0] &&
        ovl_cnt[0] == OVL_CYC - 1'b1 |=> protect_fault_flag[0] && !ch_on[0])
        else $error("Overload did not shut channel off.");
    chk_clear_works: assert property (clear_latch_bit && !fault_ev[0]
        |=> !protect_fault_flag[0])
        else $error("Clear command did not release latch.");
    chk_cpl_self: assert property (frame_valid && !wr_cmd ##1 1'b1 |-> !clear_latch_bit)
        else $error("Clear bit survived next frame.");
    chk_ot_flag: assert property (overtemp[0] |=> protect_fault_flag[0] && !ch_on[0])
        else $error("Over-temperature not latched.");
    chk_flag_hold: assert property (protect_fault_flag[0] && !clear_latch_bit
        |=> protect_fault_flag[0])
        else $error("Fault flag dropped without clear.");
    chk_ol_rdclr: assert property (rd_ol && !ol_set[0] |=> !open_load_flag[0])
        else $error("Open-load flag not cleared by read.");
    chk_ol_on: assert property (ch_on[0] |=> ol_cnt[0] == '0 && !$rose(open_load_flag[0]))
        else $error("Open-load diagnosis while on.");
    chk_dcen_write: assert property (wr_dcen |=> diag_current_enable == $past(frame.wdata))
        else $error("Diagnosis current enable not stored.");
    chk_latch_off: assert property (protect_fault_flag != '0 |->
        (ch_on & protect_fault_flag) == '0)
        else $error("Latched channel is on.");

    // Further checks on the command bit, routing, the overload delay counter, the fault latch and the upper channels.
    chk_clr_set: assert property (wr_cmd && frame.wdata[`SW_CPL_BIT]
        |=> clear_latch_bit)
        else $error("Clear bit not set by command.");

    chk_clr_stay: assert property (clear_latch_bit && !frame_valid
        |=> clear_latch_bit)
        else $error("Clear bit dropped without a frame.");

    chk_in1_route: assert property (sel_reg[1:0] == `SW_SRC_IN1 && !prot_next[0]
        |=> ch_on[0] == $past(in1))
        else $error("Channel does not follow input 1.");

    chk_in2_route: assert property (sel_reg[1:0] == `SW_SRC_IN23 && !prot_next[0]
        |=> ch_on[0] == $past(in2))
        else $error("Channel does not follow input 2.");

    chk_in3_route: assert property (IN3_MASK[4] && sel_reg[9:8] == `SW_SRC_IN23 &&
        !prot_next[4] |=> ch_on[4] == $past(in3))
        else $error("Channel does not follow input 3.");

    chk_off_upper: assert property (sel_reg[15:14] == `SW_SRC_OFF
        |=> !ch_on[7])
        else $error("Upper channel on with source off.");

    chk_ot_upper: assert property (overtemp[7]
        |=> protect_fault_flag[7] && !ch_on[7])
        else $error("Upper over-temperature not latched.");

    chk_ovl_count: assert property (overload[0] && ch_on[0] && ovl_cnt[0] != OVL_CYC - 1'b1
        |=> ovl_cnt[0] == $past(ovl_cnt[0]) + 1'b1)
        else $error("Overload delay counter did not advance.");

    chk_ovl_clear: assert property (!(overload[0] && ch_on[0])
        |=> ovl_cnt[0] == '0)
        else $error("Overload delay counter not restarted.");

    chk_ovl_bound: assert property (ovl_cnt[0] < OVL_CYC)
        else $error("Overload delay counter out of range.");

    chk_no_false: assert property (!protect_fault_flag[0] && !fault_ev[0]
        |=> !protect_fault_flag[0])
        else $error("Fault flag set without a fault.");

    chk_latch_upper: assert property (protect_fault_flag[7]
        |-> !ch_on[7])
        else $error("Latched upper channel is on.");

    // Open-load filter, hold and read path checks.
    chk_ol_filter: assert property (ol_cnt[3] != OL_CYC - 1'b1 && !open_load_flag[3]
        |=> !open_load_flag[3])
        else $error("Open-load flag set before filter delay.");

    chk_ol_set: assert property (!ch_on[3] && ol_sense[3] && ol_cnt[3] == OL_CYC - 1'b1
        |=> open_load_flag[3])
        else $error("Open-load flag not set after filter.");

    chk_ol_cnt_on: assert property (ch_on[3]
        |=> ol_cnt[3] == '0)
        else $error("Open-load filter ran while on.");

    chk_ol_hold: assert property (open_load_flag[3] && !rd_ol
        |=> open_load_flag[3])
        else $error("Open-load flag dropped without read.");

    chk_rd_pflt: assert property (frame_valid && !frame.write && frame.addr == `SW_IDX_PFLT
        |=> rdata == $past(protect_fault_flag))
        else $error("Fault flag read returned wrong data.");

    chk_rd_ol: assert property (frame_valid && !frame.write && frame.addr == `SW_IDX_OL
        |=> rdata == $past(open_load_flag))
        else $error("Open-load read returned wrong data.");

    chk_sel_hold: assert property (!wr_sel
        |=> $stable(sel_reg))
        else $error("Source select changed without write.");

    chk_dcen_hold: assert property (!wr_dcen
        |=> $stable(diag_current_enable))
        else $error("Diagnosis enable changed without write.");

endmodule // sw_chan_ctrl

// ---- inc/sw_cfg.svh ----
// Constants for the eight-channel switch control block.
// Assumes a 25 MHz system clock and an 8-bit register data path.
`ifndef SW_CFG_SVH
`define SW_CFG_SVH

`define SW_NCH 8
`define SW_DW 8
`define SW_AW 4
`define SW_CW 16
`define SW_CLK_MHZ 25
`define SW_OVL_OFF_US 60
`define SW_OVL_CYC (`SW_OVL_OFF_US * `SW_CLK_MHZ)
`define SW_OL_FILT_US 100
`define SW_OL_CYC (`SW_OL_FILT_US * `SW_CLK_MHZ)
`define SW_IN3_MASK 8'hf0

`define SW_IDX_SEL0 4'h0
`define SW_IDX_SEL1 4'h1
`define SW_IDX_SEL2 4'h2
`define SW_IDX_SEL3 4'h3
`define SW_IDX_DCEN 4'h4
`define SW_IDX_CMD 4'h5
`define SW_IDX_PFLT 4'h6
`define SW_IDX_OL 4'h7

`define SW_SEL_W 4
`define SW_CPL_BIT 0
`define SW_SEL_RST 16'h0000
`define SW_DCEN_RST 8'h00
`define SW_ZERO8 8'h00

`define SW_SRC_OFF 2'h0
`define SW_SRC_IN1 2'h1
`define SW_SRC_IN23 2'h2
`define SW_SRC_ON 2'h3

`endif

// ---- inc/sw_pkg.sv ----
// Types shared by the switch control block.
// Assumes sw_cfg.svh is on the include path.
`include "sw_cfg.svh"

package sw_pkg;
    typedef struct packed {
        logic write;
        logic [`SW_AW-1:0] addr;
        logic [`SW_DW-1:0] wdata;
    } sw_frame_t;
endpackage

// ---- dv/sw_host_model.sv ----
// Behavioural serial host that delivers decoded frames one at a time.
// Assumes the block samples the frame strobe on the rising clock edge.
`timescale 1ns/1ps
`include "sw_cfg.svh"
module sw_host_model
(
    input wire logic clk,
    output logic frame_valid,
    output sw_pkg::sw_frame_t frame
);
    import sw_pkg::*;
    initial
    begin
        frame_valid = 1'b0;
        frame = '0;
    end
    task automatic send(input logic wr, input logic [3:0] addr, input logic [7:0] data);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame <= '{wr, addr, data};
        @(posedge clk);
        frame_valid <= 1'b0;
        frame <= sw_frame_t'(~frame);
    endtask
endmodule // sw_host_model

// ---- dv/tb_switch_channel_protect_diag.sv ----
// Self-checking bench for the switch channel control block.
// Assumes the host model drives frames and the bench drives the sense lines.
`timescale 1ns/1ps
`include "sw_cfg.svh"
module tb_switch_channel_protect_diag;
    import sw_pkg::*;
    logic clk, nrst, in1, in2, in3, frame_valid, clr;
    logic [7:0] overload, overtemp, ol_sense, ch_on, dcen, pflt, olf, rdata;
    sw_frame_t frame;
    int bad_count = 0;
    int cmp_count = 0;
    sw_host_model host_u (.clk(clk), .frame_valid(frame_valid), .frame(frame));
    sw_chan_ctrl #(.OVL_CYC(16'd8), .OL_CYC(16'd5)) dut_u (.clk(clk), .nrst(nrst),
        .frame_valid(frame_valid), .frame(frame), .in1(in1), .in2(in2), .in3(in3),
        .overload(overload), .overtemp(overtemp), .ol_sense(ol_sense), .ch_on(ch_on),
        .diag_current_enable(dcen), .protect_fault_flag(pflt), .open_load_flag(olf),
        .clear_latch_bit(clr), .rdata(rdata));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_clear;
        host_u.send(1'b1, 4'h5, 8'h01);
        wait_n(2);
        chk("clr_set", {7'h0, clr}, 8'h01);
        chk("clr_flags", pflt, 8'h00);
        host_u.send(1'b0, 4'h5, 8'h00);
        wait_n(2);
        chk("clr_self", {7'h0, clr}, 8'h00);
    endtask
    task t_sel;
        logic [1:0] c;
        logic e, e4;
        for (int k = 0; k < 8; k++)
        begin
            c = k[1:0];
            in1 <= k[2];
            in2 <= ~k[2];
            in3 <= k[2];
            host_u.send(1'b1, 4'h0, {4'hf, c, c});
            host_u.send(1'b1, 4'h2, {6'h0, c});
            host_u.send(1'b0, 4'h0, 8'h00);
            wait_n(2);
            e = c == 2'h3 || (c == 2'h1 && k[2]) || (c == 2'h2 && !k[2]);
            e4 = c == 2'h3 || (c != 2'h0 && k[2]);
            chk("sel_rd", rdata, {4'h0, c, c});
            chk("sel_on", ch_on, {3'h0, e4, 2'h0, e, e});
        end
        host_u.send(1'b1, 4'h2, 8'h00);
        $display("t_sel done");
    endtask
    task t_ovl;
        host_u.send(1'b1, 4'h0, 8'h03);
        wait_n(2);
        overload <= 8'h01;
        wait_n(6);
        chk("ovl_wait", ch_on, 8'h01);
        wait_n(5);
        chk("ovl_off", ch_on, 8'h00);
        chk("ovl_flag", pflt, 8'h01);
        overload <= 8'h00;
        wait_n(4);
        chk("ovl_held", ch_on, 8'h00);
        chk("ovl_latch", pflt, 8'h01);
        host_u.send(1'b0, 4'h6, 8'h00);
        wait_n(1);
        chk("ovl_rd", rdata, 8'h01);
        t_clear;
        chk("ovl_back", ch_on, 8'h01);
        $display("t_ovl done");
    endtask
    task t_ot;
        overtemp <= 8'h04;
        wait_n(1);
        overtemp <= 8'h00;
        wait_n(2);
        chk("ot_flag", pflt, 8'h04);
        host_u.send(1'b1, 4'h1, 8'h03);
        wait_n(3);
        chk("ot_off", ch_on, 8'h01);
        t_clear;
        chk("ot_back", ch_on, 8'h05);
        host_u.send(1'b1, 4'h0, 8'h00);
        host_u.send(1'b1, 4'h1, 8'h00);
        $display("t_ot done");
    endtask
    task t_ol;
        ol_sense <= 8'h08;
        wait_n(3);
        chk("ol_filt", olf, 8'h00);
        wait_n(5);
        chk("ol_set", olf, 8'h08);
        ol_sense <= 8'h00;
        host_u.send(1'b0, 4'h7, 8'h00);
        wait_n(1);
        chk("ol_rd", rdata, 8'h08);
        chk("ol_clr", olf, 8'h00);
        host_u.send(1'b1, 4'h1, 8'h0c);
        wait_n(2);
        ol_sense <= 8'h08;
        wait_n(12);
        chk("ol_on", olf, 8'h00);
        ol_sense <= 8'h00;
        host_u.send(1'b1, 4'h1, 8'h00);
        $display("t_ol done");
    endtask
    task t_dcen;
        host_u.send(1'b1, 4'h4, 8'ha5);
        wait_n(1);
        chk("dcen", dcen, 8'ha5);
        host_u.send(1'b1, 4'h6, 8'hff);
        host_u.send(1'b0, 4'h6, 8'h00);
        wait_n(1);
        chk("pflt_ro", rdata, 8'h00);
        $display("t_dcen done");
    endtask
    initial
    begin
        nrst = 1'b0;
        {in1, in2, in3} = 3'h0;
        overload = 8'h00;
        overtemp = 8'h00;
        ol_sense = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        wait_n(4);
        t_sel;
        t_ovl;
        t_ot;
        t_ol;
        t_dcen;
        conclude;
    end
    initial
    begin
        #100000;
        bad_count++;
        conclude;
    end
endmodule // tb_switch_channel_protect_diag
